// [smia_agg.sv]
// module: system management interrupt aggregator with AHB-Lite register slave
`timescale 1ns/1ps
// Operation
// - mouse, keyboard and port-line flags follow their sources; software cannot clear them.
// - any transition on the selected infrared receive line sets the infrared flag.
// - reading the input device status register clears the infrared flag.
// - gpio status A holds flags in bits 0-2,4-7; write one clears; bit 3 reserved.
// - gpio status B holds eight flags, each cleared by writing one.
// - gpio/fan status holds bits 0-3 and 6-7, write-one-clear; bits 4-5 reserved.
// - the reserved slot at index 15 hex always reads zero.
// - peripheral enable bits 1-5 gate parallel, uarts, floppy and midi sources.
// - a source joins the group only when its enable bit is one.
// - route enable bit 5 forwards the group into the wake logic.
// - route enable bit 6 carries the group in the serial irq stream.
// - route enable bit 7 drives the group onto the dedicated pin.
// - all status and enable registers reset to zero on standby power-on reset.
module smia_agg (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire smia_pkg::smia_src_t src,
    input wire logic ir_rx_select,
    output logic mgmt_irq_out_n,
    output logic grouped_mgmt_irq_n,
    output logic group_wake_req,
    output logic group_serirq_req,
    output logic irq
);
    import smia_pkg::*;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    smia_src_t src_s;

    smia_sync #(
        .W(SRC_W)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(src),
        .q(src_s)
    );

    // ------------------------------------------------------------
    // bus address and data phase tracking
    // ------------------------------------------------------------
    smia_bus_st_t st_q;
    smia_bus_st_t st_d;
    smia_aphase_t ap_q;
    smia_aphase_t ap_d;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;

    wire addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire in_data = (st_q == ST_DATA);
    wire wr_now = in_data & ap_q.write;
    wire rd_now = in_data & ~ap_q.write;
    wire [7:0] wbyte = hwdata[7:0];

    always_comb begin
        st_d = st_q;
        ap_d = ap_q;
        unique case (st_q)
            ST_ADDR: begin
                if (addr_take) begin
                    st_d = ST_DATA;
                    ap_d.write = hwrite;
                    ap_d.idx = haddr[9:2];
                end
            end
            ST_DATA: begin
                st_d = ST_ADDR;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_ADDR;
            ap_q <= '0;
        end else begin
            st_q <= st_d;
            ap_q <= ap_d;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire hit_sts2 = (ap_q.idx == IDX_INPUT_DEVICE_STATUS);
    wire hit_sts3 = (ap_q.idx == IDX_GPIO_EVENT_STATUS_A);
    wire hit_sts4 = (ap_q.idx == IDX_GPIO_EVENT_STATUS_B);
    wire hit_sts5 = (ap_q.idx == IDX_GPIO_FAN_EVENT_STATUS);
    wire hit_rsvd = (ap_q.idx == IDX_RESERVED_ZERO_SLOT);
    wire hit_en1 = (ap_q.idx == IDX_PERIPHERAL_IRQ_ENABLE);
    wire hit_en2 = (ap_q.idx == IDX_INPUT_IRQ_ROUTE_ENABLE);
    wire hit_en3 = (ap_q.idx == IDX_GPIO_EVENT_ENABLE_A);
    wire hit_ists = (ap_q.idx == IDX_IRQ_STATUS);
    wire hit_imsk = (ap_q.idx == IDX_IRQ_MASK);

    wire wr_sts3 = wr_now & hit_sts3;
    wire wr_sts4 = wr_now & hit_sts4;
    wire wr_sts5 = wr_now & hit_sts5;
    wire wr_en1 = wr_now & hit_en1;
    wire wr_en2 = wr_now & hit_en2;
    wire wr_en3 = wr_now & hit_en3;
    wire wr_imsk = wr_now & hit_imsk;
    wire rd_sts2 = rd_now & hit_sts2;
    wire rd_ists = rd_now & hit_ists;

    // ------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------
    logic [7:0] en1_q;
    logic [7:0] en2_q;
    logic [7:0] en3_q;
    logic [2:0] imsk_q;

    wire [7:0] en1_d = wr_en1 ? (wbyte & MSK_PERIPHERAL_IRQ_ENABLE) : en1_q;
    wire [7:0] en2_d = wr_en2 ? (wbyte & MSK_INPUT_IRQ_ROUTE_ENABLE) : en2_q;
    wire [7:0] en3_d = wr_en3 ? (wbyte & MSK_GPIO_EVENT_ENABLE_A) : en3_q;
    wire [2:0] imsk_d = wr_imsk ? wbyte[2:0] : imsk_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en1_q <= RST_REG8;
            en2_q <= RST_REG8;
            en3_q <= RST_REG8;
            imsk_q <= RST_IRQ3;
        end else begin
            en1_q <= en1_d;
            en2_q <= en2_d;
            en3_q <= en3_d;
            imsk_q <= imsk_d;
        end
    end

    // ------------------------------------------------------------
    // infrared transition detection
    // ------------------------------------------------------------
    logic ir_prev_q;
    logic [1:0] ir_arm_q;

    // the selector comes from the same clock; sampling is after the mux
    wire ir_line = ir_rx_select ? src_s.ir_receive_secondary : src_s.ir_receive_primary;
    // ignore transitions until the synchroniser output has settled after reset
    wire ir_armed = (ir_arm_q == IR_ARM_CYC);
    wire ir_edge = ir_armed & (ir_line != ir_prev_q);
    wire [1:0] ir_arm_d = ir_armed ? ir_arm_q : ir_arm_q + 2'h1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_prev_q <= 1'b0;
            ir_arm_q <= 2'h0;
        end else begin
            ir_prev_q <= ir_line;
            ir_arm_q <= ir_arm_d;
        end
    end

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    logic [7:0] sts2_q;
    logic [7:0] sts3_q;
    logic [7:0] sts4_q;
    logic [7:0] sts5_q;
    logic [7:0] sts2_d;

    // level flags track the synchronised source lines
    wire ir_flag_d = ir_edge | (sts2_q[POS_INFRARED] & ~rd_sts2);

    always_comb begin
        sts2_d = RST_REG8;
        sts2_d[POS_MOUSE] = src_s.mouse_irq;
        sts2_d[POS_KEYBOARD] = src_s.keyboard_irq;
        sts2_d[POS_KBC_PORT] = src_s.kbc_port_line;
        sts2_d[POS_INFRARED] = ir_flag_d;
    end

    wire [7:0] ev3 = src_s.gpio_a & MSK_GPIO_EVENT_STATUS_A;
    wire [7:0] ev4 = src_s.gpio_b & MSK_GPIO_EVENT_STATUS_B;
    wire [7:0] ev5 = {src_s.fan_tach, 2'b00, src_s.gpio_c} & MSK_GPIO_FAN_EVENT_STATUS;
    // write-one clears use the low byte seen in the data phase
    wire [7:0] clr3 = wr_sts3 ? wbyte : RST_REG8;
    wire [7:0] clr4 = wr_sts4 ? wbyte : RST_REG8;
    wire [7:0] clr5 = wr_sts5 ? wbyte : RST_REG8;

    // a new event in the clearing cycle keeps its flag set
    wire [7:0] sts3_d = ev3 | (sts3_q & ~clr3);
    wire [7:0] sts4_d = ev4 | (sts4_q & ~clr4);
    wire [7:0] sts5_d = ev5 | (sts5_q & ~clr5);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts2_q <= RST_REG8;
            sts3_q <= RST_REG8;
            sts4_q <= RST_REG8;
            sts5_q <= RST_REG8;
        end else begin
            sts2_q <= sts2_d;
            sts3_q <= sts3_d;
            sts4_q <= sts4_d;
            sts5_q <= sts5_d;
        end
    end

    // ------------------------------------------------------------
    // grouped interrupt
    // ------------------------------------------------------------
    wire [4:0] periph_en = en1_q[POS_PERIPH_HI:POS_PERIPH_LO];
    wire periph_hit = |(src_s.periph_irq & periph_en);
    wire input_hit = |(sts2_q & en2_q & MSK_INPUT_DEVICE_STATUS);
    wire gpio_hit = |(sts3_q & en3_q);
    wire group_d = periph_hit | input_hit | gpio_hit;

    logic group_q;
    logic grouped_n_q;
    logic mgmt_irq_out_n_q;
    logic wake_q;
    logic serirq_q;

    // each route is a separate gate so one enable never disturbs another
    wire pin_d = group_d & en2_q[POS_TO_PIN];
    wire wake_d = group_d & en2_q[POS_TO_WAKE];
    wire serirq_d = group_d & en2_q[POS_TO_SERIRQ];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            group_q <= 1'b0;
            grouped_n_q <= 1'b1;
        end else begin
            group_q <= group_d;
            grouped_n_q <= ~group_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mgmt_irq_out_n_q <= 1'b1;
        end else begin
            mgmt_irq_out_n_q <= ~pin_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serirq_q <= 1'b0;
        end else begin
            serirq_q <= serirq_d;
        end
    end

    // ------------------------------------------------------------
    // block interrupt: sticky status, mask, read-to-clear
    // ------------------------------------------------------------
    logic [2:0] ists_q;
    logic irq_q;
    logic [2:0] iev;

    always_comb begin
        iev = RST_IRQ3;
        iev[POS_EV_GROUP] = group_d & ~group_q;
        iev[POS_EV_INFRARED] = ir_edge;
        iev[POS_EV_GPIO] = |(ev3 | ev4 | ev5);
    end

    wire [2:0] ists_keep = rd_ists ? RST_IRQ3 : ists_q;
    wire [2:0] ists_d = iev | ists_keep;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ists_q <= RST_IRQ3;
            irq_q <= 1'b0;
        end else begin
            ists_q <= ists_d;
            irq_q <= |(ists_d & imsk_d);
        end
    end

    // ------------------------------------------------------------
    // read data and bus response
    // ------------------------------------------------------------
    wire [7:0] rd_byte =
        hit_sts2 ? (sts2_q & MSK_INPUT_DEVICE_STATUS) :
        hit_sts3 ? (sts3_q & MSK_GPIO_EVENT_STATUS_A) :
        hit_sts4 ? (sts4_q & MSK_GPIO_EVENT_STATUS_B) :
        hit_sts5 ? (sts5_q & MSK_GPIO_FAN_EVENT_STATUS) :
        hit_rsvd ? RST_REG8 :
        hit_en1 ? en1_q :
        hit_en2 ? en2_q :
        hit_en3 ? en3_q :
        hit_ists ? {5'h00, ists_q} :
        hit_imsk ? {5'h00, imsk_q} :
        RST_REG8;

    // every NONSEQ transfer gets exactly one wait state; read data land with it
    assign hrdata_d = rd_now ? {24'h000000, rd_byte} : hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else begin
            hreadyout_q <= (st_d != ST_DATA);
            hrdata_q <= hrdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = hreadyout_q;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_q;
    assign mgmt_irq_out_n = mgmt_irq_out_n_q;
    assign grouped_mgmt_irq_n = grouped_n_q;
    assign group_wake_req = wake_q;
    assign group_serirq_req = serirq_q;
    assign irq = irq_q;

    // hsize is accepted for any value; only the low byte lane carries data
    wire unused_ok = &{1'b0, hsize, hwdata[31:8], haddr[31:10], haddr[1:0]};
endmodule

// [smia_pkg.sv]
// package: constants and types of the system management interrupt aggregator
package smia_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INPUT_DEVICE_STATUS = 8'h11;
    localparam logic [7:0] IDX_GPIO_EVENT_STATUS_A = 8'h12;
    localparam logic [7:0] IDX_GPIO_EVENT_STATUS_B = 8'h13;
    localparam logic [7:0] IDX_GPIO_FAN_EVENT_STATUS = 8'h14;
    localparam logic [7:0] IDX_RESERVED_ZERO_SLOT = 8'h15;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE = 8'h16;
    localparam logic [7:0] IDX_INPUT_IRQ_ROUTE_ENABLE = 8'h17;
    localparam logic [7:0] IDX_GPIO_EVENT_ENABLE_A = 8'h18;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

    // ------------------------------------------------------------
    // implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MSK_INPUT_DEVICE_STATUS = 8'h17;
    localparam logic [7:0] MSK_GPIO_EVENT_STATUS_A = 8'hf7;
    localparam logic [7:0] MSK_GPIO_EVENT_STATUS_B = 8'hff;
    localparam logic [7:0] MSK_GPIO_FAN_EVENT_STATUS = 8'hcf;
    localparam logic [7:0] MSK_PERIPHERAL_IRQ_ENABLE = 8'h3e;
    localparam logic [7:0] MSK_INPUT_IRQ_ROUTE_ENABLE = 8'hf7;
    localparam logic [7:0] MSK_GPIO_EVENT_ENABLE_A = 8'hf7;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [2:0] RST_IRQ3 = 3'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_MOUSE = 0;
    localparam int POS_KEYBOARD = 1;
    localparam int POS_INFRARED = 2;
    localparam int POS_KBC_PORT = 4;
    localparam int POS_PERIPH_LO = 1;
    localparam int POS_PERIPH_HI = 5;
    localparam int POS_TO_WAKE = 5;
    localparam int POS_TO_SERIRQ = 6;
    localparam int POS_TO_PIN = 7;
    localparam int POS_EV_GROUP = 0;
    localparam int POS_EV_INFRARED = 1;
    localparam int POS_EV_GPIO = 2;

    // ------------------------------------------------------------
    // counts and bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] IR_ARM_CYC = 2'h3;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam int SRC_W = 32;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] periph_irq;
        logic mouse_irq;
        logic keyboard_irq;
        logic kbc_port_line;
        logic ir_receive_primary;
        logic ir_receive_secondary;
        logic [7:0] gpio_a;
        logic [7:0] gpio_b;
        logic [3:0] gpio_c;
        logic [1:0] fan_tach;
    } smia_src_t;

    typedef struct packed {
        logic write;
        logic [7:0] idx;
    } smia_aphase_t;

    typedef enum logic {
        ST_ADDR = 1'b0,
        ST_DATA = 1'b1
    } smia_bus_st_t;

endpackage

// [smia_sync.sv]
// module: two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module smia_sync #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// [smia_agg_chk.sv]
// checker: concurrent properties on the aggregator's ports
`timescale 1ns/1ps
module smia_agg_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic mgmt_irq_out_n,
    input wire logic grouped_mgmt_irq_n,
    input wire logic group_wake_req,
    input wire logic group_serirq_req,
    input wire logic irq
);
    import smia_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_take;
        hsel && hready && hreadyout && htrans == HTRANS_NONSEQ;
    endsequence
    sequence s_rd(logic [7:0] idx);
        s_take and (!hwrite && haddr[9:2] == idx);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_one_wait;
        s_take |=> !hreadyout ##1 hreadyout && hresp == HRESP_OKAY;
    endproperty
    property p_reset_quiet;
        $rose(hresetn) |-> mgmt_irq_out_n && grouped_mgmt_irq_n && !irq
            && !group_wake_req && !group_serirq_req;
    endproperty
    property p_pin_needs_group;
        !mgmt_irq_out_n |-> !grouped_mgmt_irq_n || $past(!grouped_mgmt_irq_n);
    endproperty
    property p_wake_needs_group;
        group_wake_req |-> !grouped_mgmt_irq_n || $past(!grouped_mgmt_irq_n);
    endproperty
    property p_serirq_needs_group;
        group_serirq_req |-> !grouped_mgmt_irq_n || $past(!grouped_mgmt_irq_n);
    endproperty
    property p_rsvd_slot;
        s_rd(IDX_RESERVED_ZERO_SLOT) |-> ##2 hrdata == 32'h0;
    endproperty
    property p_sts3_rsvd;
        s_rd(IDX_GPIO_EVENT_STATUS_A) |-> ##2 hrdata[3] == 1'b0;
    endproperty
    property p_sts5_rsvd;
        s_rd(IDX_GPIO_FAN_EVENT_STATUS) |-> ##2 hrdata[5:4] == 2'h0;
    endproperty
    property p_en1_rsvd;
        s_rd(IDX_PERIPHERAL_IRQ_ENABLE) |-> ##2 hrdata[0] == 1'b0 && hrdata[7:6] == 2'h0;
    endproperty
    property p_sts2_rsvd;
        s_rd(IDX_INPUT_DEVICE_STATUS) |-> ##2 hrdata[7:5] == 3'h0 && hrdata[3] == 1'b0;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus wait state wrong");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_pin_needs_group: assert property (p_pin_needs_group) else $error("pin without group");
    a_wake_needs_group: assert property (p_wake_needs_group) else $error("wake w/o group");
    a_serirq_needs_group: assert property (p_serirq_needs_group) else $error("serirq w/o group");
    a_rsvd_slot: assert property (p_rsvd_slot) else $error("reserved slot not zero");
    a_sts3_rsvd: assert property (p_sts3_rsvd) else $error("status a bit 3 set");
    a_sts5_rsvd: assert property (p_sts5_rsvd) else $error("fan status bits 5:4 set");
    a_en1_rsvd: assert property (p_en1_rsvd) else $error("enable 1 reserved bit set");
    a_sts2_rsvd: assert property (p_sts2_rsvd) else $error("input status reserved set");
endmodule

bind smia_agg smia_agg_chk smia_agg_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mgmt_irq_out_n(mgmt_irq_out_n),
    .grouped_mgmt_irq_n(grouped_mgmt_irq_n), .group_wake_req(group_wake_req),
    .group_serirq_req(group_serirq_req), .irq(irq));

// [smia_host_model.sv]
// model: host chipset that latches each routed management interrupt it receives
`timescale 1ns/1ps
module smia_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mgmt_irq_out_n,
    input wire logic group_serirq_req,
    input wire logic group_wake_req,
    output logic [2:0] seen_q
);
    // sticky record: bit 2 wake, bit 1 serial irq, bit 0 pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 3'h0;
        end else begin
            seen_q <= seen_q | {group_wake_req, group_serirq_req, !mgmt_irq_out_n};
        end
    end
endmodule

// [system_mgmt_irq_aggregator_bench.sv]
// testbench: register and routing checks of the management interrupt aggregator
`timescale 1ns/1ps
module system_mgmt_irq_aggregator_bench;
    import smia_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata;
    smia_src_t src = '0;
    logic ir_rx_select = 1'b0;
    logic mgmt_irq_out_n, grouped_mgmt_irq_n, group_wake_req, group_serirq_req;
    logic [2:0] host_seen;
    logic [31:0] rd;
    logic [7:0] idxs [10] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
        8'h20, 8'h21};
    logic [7:0] w1c_idx [3] = '{8'h12, 8'h13, 8'h14};
    logic [7:0] w1c_msk [3] = '{8'hf7, 8'hff, 8'hcf};
    int n_mismatch = 0;
    int num_checks = 0;

    smia_agg smia_agg_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src(src),
        .ir_rx_select(ir_rx_select), .mgmt_irq_out_n(mgmt_irq_out_n),
        .grouped_mgmt_irq_n(grouped_mgmt_irq_n), .group_wake_req(group_wake_req),
        .group_serirq_req(group_serirq_req), .irq(irq));
    smia_host_model smia_host_model_i (.hclk(hclk), .hresetn(hresetn),
        .mgmt_irq_out_n(mgmt_irq_out_n), .group_serirq_req(group_serirq_req),
        .group_wake_req(group_wake_req), .seen_q(host_seen));

    initial begin
        forever #20 hclk = ~hclk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= HTRANS_IDLE;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask
    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(name, rd, {24'h0, exp});
    endtask
    task automatic settle;
        repeat (6) @(posedge hclk);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (idxs[i]) rdchk("reset value", idxs[i], 8'h00);
        chk("pin idle", {31'h0, mgmt_irq_out_n}, 32'h1);
        wr(8'h16, 8'hff);
        wr(8'h17, 8'hff);
        wr(8'h18, 8'hff);
        wr(8'h15, 8'hff);
        wr(8'h30, 8'hff);
        rdchk("en1", 8'h16, 8'h3e);
        rdchk("en2", 8'h17, 8'hf7);
        rdchk("en3", 8'h18, 8'hf7);
        rdchk("rsvd slot", 8'h15, 8'h00);
        rdchk("unmapped", 8'h30, 8'h00);
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h00);
        src.mouse_irq <= 1'b1;
        src.keyboard_irq <= 1'b1;
        src.kbc_port_line <= 1'b1;
        settle();
        rdchk("follow src", 8'h11, 8'h13);
        wr(8'h11, 8'hff);
        rdchk("no sw clear", 8'h11, 8'h13);
        src.mouse_irq <= 1'b0;
        src.keyboard_irq <= 1'b0;
        src.kbc_port_line <= 1'b0;
        settle();
        rdchk("src gone", 8'h11, 8'h00);
        src.ir_receive_secondary <= 1'b1;
        settle();
        rdchk("ir unselected", 8'h11, 8'h00);
        src.ir_receive_primary <= 1'b1;
        settle();
        rdchk("ir edge", 8'h11, 8'h04);
        rdchk("ir read clr", 8'h11, 8'h00);
        ir_rx_select <= 1'b1;
        settle();
        src.ir_receive_secondary <= 1'b0;
        settle();
        rdchk("ir second", 8'h11, 8'h04);
        for (int i = 0; i < 3; i++) begin
            src.gpio_a <= (i == 0) ? 8'hff : 8'h00;
            src.gpio_b <= (i == 1) ? 8'hff : 8'h00;
            {src.gpio_c, src.fan_tach} <= (i == 2) ? 6'h3f : 6'h00;
            settle();
            src.gpio_a <= 8'h00;
            src.gpio_b <= 8'h00;
            {src.gpio_c, src.fan_tach} <= 6'h00;
            settle();
            rdchk("w1c sticky", w1c_idx[i], w1c_msk[i]);
            wr(w1c_idx[i], 8'h00);
            rdchk("w1c zero", w1c_idx[i], w1c_msk[i]);
            wr(w1c_idx[i], 8'h01);
            rdchk("w1c one", w1c_idx[i], w1c_msk[i] & 8'hfe);
            wr(w1c_idx[i], 8'hff);
            rdchk("w1c all", w1c_idx[i], 8'h00);
        end
        chk("host idle", {29'h0, host_seen}, 32'h0);
        for (int b = 5; b < 8; b++) begin
            wr(8'h17, 8'h01 | (8'h01 << b));
            src.mouse_irq <= 1'b1;
            settle();
            chk("group on", {31'h0, grouped_mgmt_irq_n}, 32'h0);
            chk("route", {29'h0, group_wake_req, group_serirq_req, !mgmt_irq_out_n},
                32'h4 >> (b - 5));
            src.mouse_irq <= 1'b0;
            settle();
            chk("group off", {31'h0, grouped_mgmt_irq_n}, 32'h1);
        end
        chk("host saw all", {29'h0, host_seen}, 32'h7);
        wr(8'h17, 8'he0);
        src.mouse_irq <= 1'b1;
        settle();
        chk("src disabled", {31'h0, grouped_mgmt_irq_n}, 32'h1);
        src.mouse_irq <= 1'b0;
        wr(8'h17, 8'h80);
        wr(8'h16, 8'h02);
        src.periph_irq <= 5'h01;
        settle();
        chk("periph on", {31'h0, mgmt_irq_out_n}, 32'h0);
        wr(8'h16, 8'h3c);
        settle();
        chk("periph gated", {31'h0, mgmt_irq_out_n}, 32'h1);
        src.periph_irq <= 5'h00;
        wr(8'h18, 8'h01);
        src.gpio_a <= 8'h01;
        settle();
        chk("gpio group", {31'h0, mgmt_irq_out_n}, 32'h0);
        src.gpio_a <= 8'h00;
        settle();
        wr(8'h12, 8'h01);
        wr(8'h18, 8'h00);
        settle();
        chk("gpio group off", {31'h0, mgmt_irq_out_n}, 32'h1);
        bus(1'b0, 8'h20, 8'h00);
        wr(8'h21, 8'h01);
        wr(8'h17, 8'h01);
        src.mouse_irq <= 1'b1;
        settle();
        chk("irq raised", {31'h0, irq}, 32'h1);
        rdchk("irq status", 8'h20, 8'h01);
        repeat (3) @(posedge hclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(8'h21, 8'h00);
        src.mouse_irq <= 1'b0;
        settle();
        src.mouse_irq <= 1'b1;
        settle();
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdchk("masked status", 8'h20, 8'h01);
        tally_and_finish();
    end
    initial begin
        repeat (8000) @(posedge hclk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
